// ==== can_ctrl.sv ====
// Purpose: CAN controller core: bit timing, registers and message objects.
// Assumes: Frame engine on this clock supplies frame and error events.
// Notes: APB slave, always ready; read data captured at setup.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module can_ctrl
	import can_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// CAN receive pin
	input wire logic i_can_rx,
	// Bit timing strobes
	output logic o_quantum_tick,
	output logic o_sample_tick,
	output logic o_sampled_bit,
	output logic o_bit_start,
	// Frame engine
	input wire rx_frame_t i_rx_frame,
	input wire logic i_tx_done,
	input wire err_state_t i_err,
	output tx_req_t o_tx_req,
	// Controller state
	output logic o_enabled,
	output logic o_irq
);
	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_OBJ - 1; i >= 0; i--)
			if (v[i])
				r = 5'(i);
		return r;
	endfunction : first_set

	function automatic logic [31:0] onehot(input logic [4:0] i);
		return 32'h0000_0001 << i;
	endfunction : onehot

	function automatic logic [3:0] clamp_dlc(input logic [3:0] d);
		return (d > MAX_DLC) ? MAX_DLC : d;
	endfunction : clamp_dlc

	function automatic logic obj_match(input logic [15:0] c,
			input logic [28:0] oid, input logic [28:0] om, input frame_t f);
		logic [2:0] t;
		logic want_rem;
		logic kind_ok;
		logic long_ok;
		logic [28:0] cm;
		t = c[O_TYPE_LSB +: 3];
		want_rem = (t == TY_RX_REMOTE) || (t == TY_AUTO);
		// Direction and long-id checks relax only under mask filtering
		kind_ok = (f.remote == want_rem) || (c[O_IDM] && !c[O_DIRM]);
		long_ok = (f.long_id == c[O_LONG]) || (c[O_IDM] && !c[O_LONGM]);
		cm = c[O_IDM] ? om : 29'h1fff_ffff;
		cm = cm & (f.long_id ? 29'h1fff_ffff : STD_ID_MASK);
		return (t != TY_TX) && kind_ok && long_ok && (((f.id ^ oid) & cm) == '0);
	endfunction : obj_match

	// Control and timing registers
	logic ena_reg, master_reg, err_ie_reg, sts_ie_reg;
	logic [9:0] div_reg;
	logic [4:0] seg1_reg;
	logic [3:0] seg2_reg;
	logic [2:0] sjw_reg;
	// Status
	logic [2:0] lec_reg;
	logic tx_ok_reg, rx_ok_reg, ewarn_reg, epass_reg, busoff_reg;
	logic sts_pend_reg, err_pend_reg, sts_seen_reg;
	// Staging window onto one object
	logic [28:0] st_id_reg, st_mask_reg;
	logic [15:0] st_ctl_reg;
	logic [31:0] st_lo_reg, st_hi_reg;
	logic [4:0] cmd_idx_reg;
	// Object memory, each object undefined until the host stores it
	logic [28:0] id_mem [NUM_OBJ];
	logic [28:0] mask_mem [NUM_OBJ];
	logic [15:0] cfg_mem [NUM_OBJ];
	logic [3:0] dlc_mem [NUM_OBJ];
	logic [63:0] data_mem [NUM_OBJ];
	logic [31:0] valid_reg, pend_send_reg, fresh_reg, ovr_reg, obj_irq_reg;
	// Bit timing
	logic rx_s1_reg, rx_s2_reg, rx_prev_reg, edge_pend_reg;
	logic [9:0] div_cnt_reg;
	logic [4:0] pos_reg;

	logic setup, acc, wr, rd_status, cmd_wr;
	logic do_store, do_load, do_rel;
	logic [4:0] cidx;
	logic [31:0] sel_m, store_m, load_m, rel_m, clr_m, done_m, rx_m, auto_m;
	logic [31:0] match, cand, cause, status_word, rdata_next;
	logic slverr_next, rx_hit, st_tx_type, tq_tick, last_q;
	logic [4:0] rx_idx, last_pos, sjw5, pos_next;
	logic [2:0] st_type;

	assign setup = i_psel & ~i_penable;
	assign acc = i_psel & i_penable;
	assign wr = acc & i_pwrite;
	assign rd_status = acc & ~i_pwrite & (i_paddr == A_STATUS);
	assign cmd_wr = wr & (i_paddr == A_OBJ_CMD);
	assign cidx = i_pwdata[CMD_IDX_LSB +: 5];
	assign do_store = cmd_wr & (i_pwdata[1:0] == CMD_STORE);
	assign do_load = cmd_wr & (i_pwdata[1:0] == CMD_LOAD);
	assign do_rel = cmd_wr & (i_pwdata[1:0] == CMD_RELEASE);
	assign o_pready = 1'b1;
	assign o_enabled = ena_reg;

	always_comb
	begin
		for (int i = 0; i < NUM_OBJ; i++)
			match[i] = valid_reg[i] &&
				obj_match(cfg_mem[i], id_mem[i], mask_mem[i], i_rx_frame.frame);
	end

	// Lowest numbered matching object takes the frame
	assign rx_hit = ena_reg & i_rx_frame.valid & (|match);
	assign rx_idx = first_set(match);
	assign rx_m = rx_hit ? onehot(rx_idx) : '0;
	assign auto_m = (i_rx_frame.frame.remote &&
		cfg_mem[rx_idx][O_TYPE_LSB +: 3] == TY_AUTO) ? rx_m : '0;
	assign done_m = (i_tx_done & o_tx_req.valid) ? onehot(o_tx_req.index) : '0;
	assign sel_m = onehot(cidx);
	assign store_m = do_store ? sel_m : '0;
	assign load_m = do_load ? sel_m : '0;
	assign rel_m = do_rel ? sel_m : '0;
	assign clr_m = store_m | load_m | rel_m;
	assign st_type = st_ctl_reg[O_TYPE_LSB +: 3];
	assign st_tx_type = (st_type == TY_TX) || (st_type == TY_TX_REMOTE);
	assign cand = pend_send_reg & valid_reg & ~done_m;

	always_comb
	begin
		status_word = '0;
		status_word[S_LEC_LSB +: 3] = lec_reg;
		status_word[S_TXOK] = tx_ok_reg;
		status_word[S_RXOK] = rx_ok_reg;
		status_word[S_EPASS] = epass_reg;
		status_word[S_EWARN] = ewarn_reg;
		status_word[S_BUSOFF] = busoff_reg;
		if (sts_pend_reg || err_pend_reg)
			cause = CAUSE_STATUS;
		else if (|obj_irq_reg)
			cause = {27'h0, first_set(obj_irq_reg)} + 32'h0000_0001;
		else
			cause = '0;
	end

	always_comb
	begin
		slverr_next = 1'b0;
		case (i_paddr)
			A_CTRL: rdata_next = {28'h0, sts_ie_reg, err_ie_reg, master_reg,
				ena_reg};
			A_TIMING: rdata_next = {9'h0, sjw_reg, seg2_reg, 1'b0, seg1_reg,
				div_reg};
			A_STATUS: rdata_next = status_word;
			A_CAUSE: rdata_next = cause;
			A_IRQ_PEND: rdata_next = obj_irq_reg;
			A_PEND_SEND: rdata_next = pend_send_reg;
			A_FRESH: rdata_next = fresh_reg;
			A_VALID: rdata_next = valid_reg;
			A_OBJ_ID: rdata_next = {3'h0, st_id_reg};
			A_OBJ_MASK: rdata_next = {3'h0, st_mask_reg};
			A_OBJ_CTL: rdata_next = {16'h0, st_ctl_reg};
			A_OBJ_LO: rdata_next = st_lo_reg;
			A_OBJ_HI: rdata_next = st_hi_reg;
			A_OBJ_CMD: rdata_next = {19'h0, cmd_idx_reg, 8'h00};
			default:
			begin
				rdata_next = '0;
				slverr_next = 1'b1;
			end
		endcase
	end

	// Read data is frozen at setup so read-to-clear drops only what was seen
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_prdata <= '0;
			o_pslverr <= 1'b0;
			sts_seen_reg <= 1'b0;
		end
		else if (setup)
		begin
			o_prdata <= rdata_next;
			o_pslverr <= slverr_next;
			sts_seen_reg <= sts_pend_reg | err_pend_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ena_reg <= 1'b0;
			master_reg <= 1'b0;
			err_ie_reg <= 1'b0;
			sts_ie_reg <= 1'b0;
			div_reg <= DIV_RST;
			seg1_reg <= SEG1_RST;
			seg2_reg <= SEG2_RST;
			sjw_reg <= SJW_RST;
		end
		else if (wr && i_paddr == A_CTRL)
		begin
			ena_reg <= i_pwdata[C_ENABLE];
			master_reg <= i_pwdata[C_MASTER];
			err_ie_reg <= i_pwdata[C_ERR_IE];
			sts_ie_reg <= i_pwdata[C_STS_IE];
		end
		// An out-of-range field refuses the whole timing write
		else if (wr && i_paddr == A_TIMING &&
			i_pwdata[T_SEG1_LSB +: 5] >= SEG1_MIN &&
			i_pwdata[T_SEG1_LSB +: 5] <= SEG1_MAX &&
			i_pwdata[T_SEG2_LSB +: 4] >= SEG2_MIN &&
			i_pwdata[T_SEG2_LSB +: 4] <= SEG2_MAX &&
			i_pwdata[T_SJW_LSB +: 3] >= SJW_MIN &&
			i_pwdata[T_SJW_LSB +: 3] <= SJW_MAX &&
			i_pwdata[T_DIV_LSB +: 10] >= DIV_MIN)
		begin
			div_reg <= i_pwdata[T_DIV_LSB +: 10];
			seg1_reg <= i_pwdata[T_SEG1_LSB +: 5];
			seg2_reg <= i_pwdata[T_SEG2_LSB +: 4];
			sjw_reg <= i_pwdata[T_SJW_LSB +: 3];
		end
	end

	// Status flags; a hardware set wins over a same-cycle clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lec_reg <= LEC_NONE;
			tx_ok_reg <= 1'b0;
			rx_ok_reg <= 1'b0;
			ewarn_reg <= 1'b0;
			epass_reg <= 1'b0;
			busoff_reg <= 1'b0;
			sts_pend_reg <= 1'b0;
			err_pend_reg <= 1'b0;
		end
		else
		begin
			ewarn_reg <= i_err.ewarn;
			epass_reg <= i_err.epass;
			busoff_reg <= i_err.busoff;
			if (i_err.lec_valid)
				lec_reg <= i_err.last_error_code;
			tx_ok_reg <= (tx_ok_reg & ~(rd_status & o_prdata[S_TXOK])) |
				(|done_m);
			rx_ok_reg <= (rx_ok_reg & ~(rd_status & o_prdata[S_RXOK])) |
				rx_hit;
			sts_pend_reg <= (sts_pend_reg & ~(rd_status & sts_seen_reg)) |
				(|done_m) | rx_hit |
				(i_err.lec_valid && i_err.last_error_code != LEC_NONE);
			err_pend_reg <= (err_pend_reg & ~(rd_status & sts_seen_reg)) |
				(i_err.busoff & ~busoff_reg) | (i_err.ewarn & ~ewarn_reg) |
				(i_err.epass & ~epass_reg);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else
			o_irq <= master_reg & ((sts_ie_reg & sts_pend_reg) |
				(err_ie_reg & err_pend_reg) | (|obj_irq_reg));
	end

	// Staging window: host written, refilled by load
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_id_reg <= '0;
			st_mask_reg <= '0;
			st_ctl_reg <= '0;
			st_lo_reg <= '0;
			st_hi_reg <= '0;
			cmd_idx_reg <= '0;
		end
		else if (do_load)
		begin
			cmd_idx_reg <= cidx;
			st_id_reg <= id_mem[cidx];
			st_mask_reg <= mask_mem[cidx];
			st_ctl_reg <= cfg_mem[cidx];
			st_ctl_reg[O_FRESH] <= fresh_reg[cidx];
			st_ctl_reg[O_OVR] <= ovr_reg[cidx];
			st_ctl_reg[O_DLC_LSB +: 4] <= dlc_mem[cidx];
			st_lo_reg <= data_mem[cidx][31:0];
			st_hi_reg <= data_mem[cidx][63:32];
		end
		else if (cmd_wr)
			cmd_idx_reg <= cidx;
		else if (wr)
		begin
			case (i_paddr)
				A_OBJ_ID: st_id_reg <= i_pwdata[28:0];
				A_OBJ_MASK: st_mask_reg <= i_pwdata[28:0];
				A_OBJ_CTL:
				begin
					st_ctl_reg <= i_pwdata[15:0];
					st_ctl_reg[O_DLC_LSB +: 4] <=
						clamp_dlc(i_pwdata[O_DLC_LSB +: 4]);
					st_ctl_reg[O_REMOTE] <=
						(i_pwdata[O_TYPE_LSB +: 3] == TY_TX_REMOTE) ||
						(i_pwdata[O_TYPE_LSB +: 3] == TY_RX_REMOTE) ||
						(i_pwdata[O_TYPE_LSB +: 3] == TY_AUTO);
					st_ctl_reg[O_FRESH] <= 1'b0;
					st_ctl_reg[O_OVR] <= 1'b0;
				end
				A_OBJ_LO: st_lo_reg <= i_pwdata;
				A_OBJ_HI: st_hi_reg <= i_pwdata;
				default: st_ctl_reg <= st_ctl_reg;
			endcase
		end
	end

	// Object memory; a host store overrides a same-cycle reception
	always_ff @(posedge i_clk)
	begin
		if (rx_hit)
		begin
			id_mem[rx_idx] <= i_rx_frame.frame.long_id ?
				i_rx_frame.frame.id :
				(i_rx_frame.frame.id & STD_ID_MASK);
			if (!i_rx_frame.frame.remote)
			begin
				dlc_mem[rx_idx] <= clamp_dlc(i_rx_frame.frame.dlc);
				data_mem[rx_idx] <= i_rx_frame.frame.data;
			end
		end
		if (do_store)
		begin
			id_mem[cidx] <= st_id_reg;
			mask_mem[cidx] <= st_mask_reg;
			cfg_mem[cidx] <= st_ctl_reg;
			dlc_mem[cidx] <= st_ctl_reg[O_DLC_LSB +: 4];
			data_mem[cidx] <= {st_hi_reg, st_lo_reg};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			valid_reg <= '0;
			pend_send_reg <= '0;
			fresh_reg <= '0;
			ovr_reg <= '0;
			obj_irq_reg <= '0;
		end
		else
		begin
			valid_reg <= (valid_reg & ~rel_m) | store_m;
			pend_send_reg <= (pend_send_reg & ~(done_m | clr_m)) |
				(st_tx_type ? store_m : '0) | auto_m;
			fresh_reg <= (fresh_reg & ~clr_m) | rx_m;
			ovr_reg <= (ovr_reg & ~clr_m) | (rx_m & fresh_reg);
			obj_irq_reg <= (obj_irq_reg & ~clr_m) |
				(rx_m & {NUM_OBJ{cfg_mem[rx_idx][O_RXIE]}}) |
				(done_m & {NUM_OBJ{cfg_mem[o_tx_req.index][O_TXIE]}});
		end
	end

	// Offer top priority pending object until sent
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_tx_req <= '0;
		else if (!ena_reg)
			o_tx_req.valid <= 1'b0;
		else if (!o_tx_req.valid || i_tx_done)
		begin
			o_tx_req.valid <= |cand;
			o_tx_req.index <= first_set(cand);
			o_tx_req.frame.long_id <= cfg_mem[first_set(cand)][O_LONG];
			o_tx_req.frame.remote <=
				cfg_mem[first_set(cand)][O_TYPE_LSB +: 3] == TY_TX_REMOTE;
			o_tx_req.frame.id <= id_mem[first_set(cand)];
			o_tx_req.frame.dlc <= dlc_mem[first_set(cand)];
			o_tx_req.frame.data <= data_mem[first_set(cand)];
		end
	end

	// Quantum divider, bit position, resync by jump width
	assign sjw5 = {2'h0, sjw_reg};
	assign last_pos = seg1_reg + {1'b0, seg2_reg};
	assign tq_tick = ena_reg && (div_cnt_reg == div_reg - 10'h001);
	assign last_q = pos_reg == last_pos;

	always_comb
	begin
		if (edge_pend_reg && pos_reg != 5'h00 && pos_reg <= seg1_reg)
			pos_next = pos_reg + 5'h01 -
				((pos_reg < sjw5) ? pos_reg : sjw5);
		else if (edge_pend_reg && pos_reg > seg1_reg)
			pos_next = (last_pos - pos_reg <= sjw5) ? 5'h01 :
				pos_reg + 5'h01 + sjw5;
		else
			pos_next = last_q ? 5'h00 : pos_reg + 5'h01;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end
		else
		begin
			rx_s1_reg <= i_can_rx;
			rx_s2_reg <= rx_s1_reg;
			rx_prev_reg <= rx_s2_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			div_cnt_reg <= '0;
			pos_reg <= '0;
			edge_pend_reg <= 1'b0;
			o_quantum_tick <= 1'b0;
			o_sample_tick <= 1'b0;
			o_sampled_bit <= 1'b1;
			o_bit_start <= 1'b0;
		end
		else if (!ena_reg)
		begin
			div_cnt_reg <= '0;
			pos_reg <= '0;
			edge_pend_reg <= 1'b0;
			o_quantum_tick <= 1'b0;
			o_sample_tick <= 1'b0;
			o_bit_start <= 1'b0;
		end
		else
		begin
			div_cnt_reg <= tq_tick ? 10'h000 : div_cnt_reg + 10'h001;
			o_quantum_tick <= tq_tick;
			o_sample_tick <= tq_tick && pos_reg == seg1_reg;
			o_bit_start <= tq_tick && pos_next == 5'h00;
			if (tq_tick && pos_reg == seg1_reg)
				o_sampled_bit <= rx_s2_reg;
			if (tq_tick)
			begin
				pos_reg <= pos_next;
				edge_pend_reg <= 1'b0;
			end
			else if (rx_prev_reg && !rx_s2_reg)
				edge_pend_reg <= 1'b1;
		end
	end
endmodule : can_ctrl
`default_nettype wire

// ==== can_ctrl_pkg.sv ====
// Purpose: Constants and carrier types for the CAN controller block.
// Assumes: APB register access, 32 message objects, one 40 MHz clock.
// Notes: Function
// Function
// - Prop+phase-1 segment (sync quantum excluded) accepted only from 2 to 16.
// - Second phase segment accepted only from 1 to 8.
// - Resync jump width accepted only from 1 to 4.
// - Quantum is module clock divided by 1 to 1023.
// - Bit lasts first segment plus second phase plus one sync quantum.
// - Bit rate is clock over divider times total quanta per bit.
// - No interrupt at all while the global interrupt enable is clear.
// - Error and status interrupts each pass only under their own enable.
// - Status shows bus-off, warning level and error-passive level.
// - Receive and transmit success flags set per frame, cleared by status read.
// - Last error code: none, stuff, form, ack, stuck 1, stuck 0, CRC.
// - 32-bit bitmaps of pending sends, fresh data, valid objects.
// - Per-object send and receive irq enables, read back with the object.
// - Mask filter; direction and long-id filters only under mask filter.
// - Per-object fresh flag; overrun when unread data is overwritten.
// - Types: send, send remote, receive, receive remote, auto answer.
// - Per-object identifier, standard or long width by a long-id flag.
// - Per-object data length given as number of data bytes.
// - Two interrupt views: cause, and pending across all objects.
// - 32 objects; lower number has priority for actions and irqs.
// - Off the bus after reset; object memory undefined until stored.
// - Status read clears status irq; object load clears its irq.
package can_ctrl_pkg;
	localparam int NUM_OBJ = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TIMING = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_CAUSE = 8'h0c;
	localparam logic [7:0] A_IRQ_PEND = 8'h10;
	localparam logic [7:0] A_PEND_SEND = 8'h14;
	localparam logic [7:0] A_FRESH = 8'h18;
	localparam logic [7:0] A_VALID = 8'h1c;
	localparam logic [7:0] A_OBJ_ID = 8'h20;
	localparam logic [7:0] A_OBJ_MASK = 8'h24;
	localparam logic [7:0] A_OBJ_CTL = 8'h28;
	localparam logic [7:0] A_OBJ_LO = 8'h2c;
	localparam logic [7:0] A_OBJ_HI = 8'h30;
	localparam logic [7:0] A_OBJ_CMD = 8'h34;
	localparam int C_ENABLE = 0;
	localparam int C_MASTER = 1;
	localparam int C_ERR_IE = 2;
	localparam int C_STS_IE = 3;
	localparam int T_DIV_LSB = 0;
	localparam int T_SEG1_LSB = 10;
	localparam int T_SEG2_LSB = 16;
	localparam int T_SJW_LSB = 20;
	localparam logic [9:0] DIV_RST = 10'h001;
	localparam logic [4:0] SEG1_RST = 5'h04;
	localparam logic [3:0] SEG2_RST = 4'h3;
	localparam logic [2:0] SJW_RST = 3'h1;
	localparam logic [9:0] DIV_MIN = 10'h001;
	localparam logic [4:0] SEG1_MIN = 5'h02;
	localparam logic [4:0] SEG1_MAX = 5'h10;
	localparam logic [3:0] SEG2_MIN = 4'h1;
	localparam logic [3:0] SEG2_MAX = 4'h8;
	localparam logic [2:0] SJW_MIN = 3'h1;
	localparam logic [2:0] SJW_MAX = 3'h4;
	localparam int S_LEC_LSB = 0;
	localparam int S_TXOK = 3;
	localparam int S_RXOK = 4;
	localparam int S_EPASS = 5;
	localparam int S_EWARN = 6;
	localparam int S_BUSOFF = 7;
	localparam logic [2:0] LEC_NONE = 3'h0;
	localparam logic [2:0] LEC_STUFF = 3'h1;
	localparam logic [2:0] LEC_FORM = 3'h2;
	localparam logic [2:0] LEC_ACK = 3'h3;
	localparam logic [2:0] LEC_BIT1 = 3'h4;
	localparam logic [2:0] LEC_BIT0 = 3'h5;
	localparam logic [2:0] LEC_CRC = 3'h6;
	localparam logic [31:0] CAUSE_STATUS = 32'h0000_8000;
	localparam int O_DLC_LSB = 0;
	localparam int O_TXIE = 4;
	localparam int O_RXIE = 5;
	localparam int O_LONG = 6;
	localparam int O_IDM = 7;
	localparam int O_DIRM = 8;
	localparam int O_LONGM = 9;
	localparam int O_REMOTE = 10;
	localparam int O_FRESH = 11;
	localparam int O_OVR = 12;
	localparam int O_TYPE_LSB = 13;
	localparam logic [2:0] TY_TX = 3'h0;
	localparam logic [2:0] TY_TX_REMOTE = 3'h1;
	localparam logic [2:0] TY_RX = 3'h2;
	localparam logic [2:0] TY_RX_REMOTE = 3'h3;
	localparam logic [2:0] TY_AUTO = 3'h4;
	localparam logic [1:0] CMD_STORE = 2'h1;
	localparam logic [1:0] CMD_LOAD = 2'h2;
	localparam logic [1:0] CMD_RELEASE = 2'h3;
	localparam int CMD_IDX_LSB = 8;
	localparam logic [3:0] MAX_DLC = 4'h8;
	localparam logic [28:0] STD_ID_MASK = 29'h0000_07ff;

	typedef struct packed {
		logic long_id;
		logic remote;
		logic [28:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} frame_t;

	typedef struct packed {
		logic valid;
		frame_t frame;
	} rx_frame_t;

	typedef struct packed {
		logic valid;
		logic [4:0] index;
		frame_t frame;
	} tx_req_t;

	typedef struct packed {
		logic lec_valid;
		logic [2:0] last_error_code;
		logic ewarn;
		logic epass;
		logic busoff;
	} err_state_t;
endpackage : can_ctrl_pkg

// ==== can_ctrl_monitor.sv ====
// Purpose: Port-level checks for the CAN controller core.
// Assumes: One clock domain; sees only can_ctrl ports.
// Notes: Control bits shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_monitor
	import can_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Timing and engine
	input wire logic o_sample_tick,
	input wire logic o_bit_start,
	input wire logic i_tx_done,
	input wire tx_req_t o_tx_req,
	input wire logic o_enabled,
	input wire logic o_irq
);
	logic [3:0] ctrl_reg;
	logic wr_acc;
	assign wr_acc = i_psel && i_penable && i_pwrite;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			ctrl_reg <= 4'h0;
		else if (wr_acc && i_paddr == A_CTRL)
			ctrl_reg <= i_pwdata[3:0];
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_ready_high: assert property (o_pready)
		else $error("pready low");
	a_enable_echo: assert property (o_enabled == ctrl_reg[C_ENABLE])
		else $error("enable mismatch");
	a_master_gate: assert property (!ctrl_reg[C_MASTER] [*3] |-> !o_irq)
		else $error("irq while masked");
	a_off_no_send: assert property (!ctrl_reg[C_ENABLE] [*2] |-> !o_tx_req.valid)
		else $error("send while off");
	a_bad_addr_err: assert property (i_psel && !i_penable |=> o_pslverr ==
		(i_paddr > A_OBJ_CMD || i_paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	a_bad_addr_zero: assert property (i_psel && i_penable && o_pslverr
		&& !i_pwrite |-> o_prdata == 32'h0)
		else $error("unmapped read");
	a_send_holds: assert property (o_tx_req.valid && !i_tx_done && !wr_acc
		|=> o_tx_req.valid && $stable(o_tx_req.index))
		else $error("send dropped");
	a_sample_apart: assert property (o_sample_tick |-> !o_bit_start)
		else $error("sample at bit start");
endmodule : can_ctrl_monitor
bind can_ctrl can_ctrl_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
	.o_pready(o_pready), .o_pslverr(o_pslverr), .o_sample_tick(o_sample_tick),
	.o_bit_start(o_bit_start), .i_tx_done(i_tx_done), .o_tx_req(o_tx_req),
	.o_enabled(o_enabled), .o_irq(o_irq));
`default_nettype wire

// ==== can_far_node.sv ====
// Purpose: Far side: frame engine and other bus nodes.
// Assumes: Same clock as the controller.
// Notes: Send answers alternate slow and prompt.
`timescale 1ns/1ps
`default_nettype none
module can_far_node
	import can_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Commands from the bench
	input wire logic i_send,
	input wire frame_t i_frame,
	input wire err_state_t i_err_cmd,
	// Controller side
	input wire tx_req_t i_tx_req,
	output rx_frame_t o_rx_frame,
	output logic o_tx_done,
	output err_state_t o_err,
	output logic o_can_rx,
	output tx_req_t o_seen
);
	logic [3:0] wait_cnt;
	logic slow;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rx_frame <= '0;
			o_err <= '0;
		end
		else
		begin
			o_rx_frame <= {i_send, i_frame};
			o_err <= i_err_cmd;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_cnt <= 4'h0;
			slow <= 1'b1;
			o_tx_done <= 1'b0;
			o_seen <= '0;
			o_can_rx <= 1'b1;
		end
		else
		begin
			o_tx_done <= 1'b0;
			o_can_rx <= !(i_tx_req.valid && wait_cnt[0]);
			if (i_tx_req.valid && !o_tx_done)
			begin
				if (wait_cnt == (slow ? 4'h9 : 4'h2))
				begin
					o_tx_done <= 1'b1;
					o_seen <= i_tx_req;
					wait_cnt <= 4'h0;
					slow <= !slow;
				end
				else
					wait_cnt <= wait_cnt + 4'h1;
			end
			else
				wait_cnt <= 4'h0;
		end
	end
endmodule : can_far_node
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Register-level tests of the CAN controller core.
// Assumes: APB master tasks; far side modelled by can_far_node.
// Notes: Tests are register call sequences.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import can_ctrl_pkg::*;
;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, send = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic pready, pslverr, rerr, qtick, stick, sbit, bstart, txd, enabled, irq;
	logic canrx;
	rx_frame_t rxf;
	err_state_t errs, ecmd = '0;
	tx_req_t txr, seen;
	frame_t fr = '0;
	int n_fail = 0, checks_done = 0, c;
	int bad[7][4] = '{'{0,4,3,1}, '{1,1,3,1}, '{1,17,3,1}, '{1,4,0,1},
		'{1,4,9,1}, '{1,4,3,0}, '{1,4,3,5}};
	int good[2][4] = '{'{1,2,1,1}, '{3,16,8,4}};
	localparam logic [31:0] RXC = {16'h0, TY_RX, 13'h00e8};
	always #12.5 clk = ~clk;
	can_ctrl DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_can_rx(canrx), .o_quantum_tick(qtick),
		.o_sample_tick(stick), .o_sampled_bit(sbit), .o_bit_start(bstart),
		.i_rx_frame(rxf), .i_tx_done(txd), .i_err(errs), .o_tx_req(txr),
		.o_enabled(enabled), .o_irq(irq));
	can_far_node u_far (.i_clk(clk), .i_rst_n(rst_n), .i_send(send),
		.i_frame(fr), .i_err_cmd(ecmd), .i_tx_req(txr), .o_rx_frame(rxf),
		.o_tx_done(txd), .o_err(errs), .o_can_rx(canrx), .o_seen(seen));
	function automatic logic [31:0] tw(input int d, s1, s2, j);
		return 32'(d) | 32'(s1) << T_SEG1_LSB | 32'(s2) << T_SEG2_LSB
			| 32'(j) << T_SJW_LSB;
	endfunction : tw
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			$display("Error %s exp %h got %h", n, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdata);
	endtask : rd
	task automatic cmd(input logic [1:0] op, input logic [4:0] i);
		apb(1'b1, A_OBJ_CMD, {19'h0, i, 6'h0, op});
	endtask : cmd
	task automatic store(input logic [4:0] i, input logic [31:0] ctl);
		apb(1'b1, A_OBJ_CTL, ctl);
		cmd(CMD_STORE, i);
	endtask : store
	task automatic put(input logic [28:0] id);
		fr <= {1'b1, 1'b0, id, 4'h8, 64'h8877_6655_4433_2211};
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : put
	task automatic last_error_code(input logic [2:0] code);
		ecmd.lec_valid <= 1'b1;
		ecmd.last_error_code <= code;
		@(posedge clk);
		ecmd.lec_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : last_error_code
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#(25 * 20000);
		n_fail++;
		$display("Error watchdog exp done got timeout");
		report_and_stop();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd("timing", A_TIMING, tw(1, 4, 3, 1));
		rd("valid", A_VALID, 32'h0);
		chk("enabled", 32'h0, enabled);
		apb(1'b0, 8'h38, 32'h0);
		chk("slverr", 32'h1, rerr);
		chk("unmapped", 32'h0, rdata);
		$display("test reset done");
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, A_TIMING, tw(bad[i][0], bad[i][1], bad[i][2], bad[i][3]));
			rd("timing", A_TIMING, tw(1, 4, 3, 1));
		end
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, A_TIMING, tw(good[i][0], good[i][1], good[i][2], good[i][3]));
			apb(1'b1, A_CTRL, 32'h1);
			rd("timing", A_TIMING, tw(good[i][0], good[i][1], good[i][2],
				good[i][3]));
			for (int k = 0; k < 3; k++)
			begin
				c = 0;
				do
				begin
					@(posedge clk);
					c++;
				end
				while (bstart !== 1'b1);
			end
			chk("bit clocks", good[i][0] * (good[i][1] + good[i][2] + 1), c);
		end
		$display("test timing done");
		apb(1'b1, A_OBJ_ID, 32'h0abc_1234);
		apb(1'b1, A_OBJ_MASK, 32'h1fff_ffff);
		apb(1'b1, A_OBJ_LO, 32'h4433_2211);
		apb(1'b1, A_OBJ_HI, 32'h8877_6655);
		store(5'd0, RXC);
		rd("valid", A_VALID, 32'h1);
		apb(1'b1, A_CTRL, 32'h3);
		put(29'h0abc_1234);
		rd("fresh", A_FRESH, 32'h1);
		rd("irq pend", A_IRQ_PEND, 32'h1);
		rd("status", A_STATUS, 32'h1 << S_RXOK);
		rd("status", A_STATUS, 32'h0);
		rd("cause", A_CAUSE, 32'h1);
		chk("irq", 32'h1, irq);
		apb(1'b1, A_CTRL, 32'h1);
		@(posedge clk);
		chk("irq", 32'h0, irq);
		apb(1'b1, A_CTRL, 32'h3);
		put(29'h0abc_1234);
		cmd(CMD_LOAD, 5'd0);
		rd("ctl", A_OBJ_CTL, RXC | 32'h1800);
		rd("data", A_OBJ_LO, 32'h4433_2211);
		chk("irq", 32'h0, irq);
		put(29'h0abc_1235);
		rd("fresh", A_FRESH, 32'h0);
		$display("test receive done");
		store(5'd1, {16'h0, TY_TX, 13'h005f});
		rd("send map", A_PEND_SEND, 32'h2);
		repeat (14) @(posedge clk);
		chk("sent index", 32'h1, seen.index);
		chk("sent length", 32'(MAX_DLC), seen.frame.dlc);
		rd("send map", A_PEND_SEND, 32'h0);
		rd("status", A_STATUS, 32'h18);
		rd("cause", A_CAUSE, 32'h2);
		cmd(CMD_LOAD, 5'd1);
		for (int t = 0; t < 5; t++)
		begin
			store(5'd4, {16'h0, 3'(t), 13'h0});
			cmd(CMD_LOAD, 5'd4);
			rd("ctl", A_OBJ_CTL, {16'h0, 3'(t), 2'h0, 1'(t % 2 + t / 4), 10'h0});
			chk("type", 32'(t), rdata[15:13]);
		end
		cmd(CMD_RELEASE, 5'd4);
		rd("valid", A_VALID, 32'h3);
		$display("test send done");
		repeat (20) @(posedge clk);
		apb(1'b0, A_STATUS, 32'h0);
		apb(1'b1, A_CTRL, 32'h7);
		for (int e = 1; e < 7; e++)
		begin
			last_error_code(3'(e));
			rd("lec", A_STATUS, 32'(e));
		end
		chk("irq", 32'h0, irq);
		apb(1'b1, A_CTRL, 32'hb);
		last_error_code(LEC_CRC);
		rd("cause", A_CAUSE, CAUSE_STATUS);
		chk("irq", 32'h1, irq);
		rd("status", A_STATUS, 32'(LEC_CRC));
		repeat (2) @(posedge clk);
		chk("irq", 32'h0, irq);
		ecmd <= '{1'b0, 3'h0, 1'b1, 1'b1, 1'b1};
		repeat (3) @(posedge clk);
		rd("levels", A_STATUS, 32'he0 | 32'(LEC_CRC));
		$display("test status done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
